// ===== verilog/wmsc_top.sv
// wmsc_top: serial command port, limit store and watchdog sequencer
// assumes: pins arrive asynchronous to pclk; serial clock much slower than pclk
// Operation
// [R1] select low, first four bits give mode
// [R2] mode 1000 plus twelve configuration bits
// [R3] out-of-window enabled input raises interrupt
// [R4] differential pair uses lower channel limits
// [R5] select after interrupt shifts out crossings
// [R6] 1001, address, limit byte writes one limit
// [R7] limit byte is unsigned fraction, msb half
// [R8] write-all fills every limit in order
// [R9] 1011 plus address returns one limit
// [R10] read-all sends every limit, from zero
// [R11] single conversion with four selection bits
// [R12] auto mode cycles channels after each result
// [R13] test mode sticks until power removal
// [R14] timebase halved, conversion within eighteen periods
// [R15] sample on rise, output valid at fall
// [R16] msb first except limits and results
// [R17] interrupt only on actual crossing
// [R18] even address lower, odd upper limit
// [R19] two-channel variant decodes two address bits
// [R20] first crossing tagged, rest rechecked, status
// [R21] host reads status after interrupt
// [R22] conversions give eight-bit results
// [R23] power-up monitoring, power-fail flag bit
// [R24] three configuration bits per channel pair
// [R25] short select high leaves monitoring
// [R26] host sends leading one in mode
// [R27] early select release abandons command
// [R28] pins cross domains through synchronisers
`timescale 1ns/100ps
`include "wmsc_map.svh"
module wmsc_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cs_n,
  input  wire logic        serial_clk,
  input  wire logic        serial_in_line,
  output logic             serial_out_o,
  output logic             serial_out_oe,
  input  wire logic        conversion_timebase,
  output logic             int_out,
  output logic             int_oe,
  output logic             eoc,
  output logic             below_window_n,
  output logic             above_window_n,
  output logic      [3:0]  mux_sel,
  output logic      [7:0]  dac_code,
  input  wire logic        cmp_above
);
  import wmsc_pkg::*;

  // power-up state: monitoring with power-fail flag and interrupt pending
  localparam wmsc_st_t ST_RST = '{ck_s: 3'h0, cs_s: 3'h7, mode: `WMSC_M_WD,
    pf: 1'b1, intf: 1'b1, eight: `WMSC_CFG_RST, cshi: `WMSC_CSHI_8CH,
    belw_n: 1'b1, abov_n: 1'b1, ws: WS_PICK, default: '0};  // [R23]

  wmsc_st_t   st_ff;     // registered state
  wmsc_st_t   nxt_st;    // next state
  logic [7:0] ram_q;     // limit store read data

  // bit reversal, limits and results travel lsb first
  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      rev8[i] = v[7 - i];
    end
  endfunction : rev8

  // configuration group of the pair holding channel c
  function automatic logic [2:0] pcfg(input logic [2:0] c, input logic [11:0] cfg);
    pcfg = 3'(cfg >> (4'(c[2:1]) * 4'h3));  // [R24]
  endfunction : pcfg

  // channel enabled; odd half of a differential pair is folded into even
  function automatic logic ch_on(input logic [2:0] c, input logic [11:0] cfg,
                                 input logic e8);
    ch_on = (e8 | (c < 3'h2)) &
            (c[0] ? (pcfg(c, cfg) == `WMSC_PC_SE) : (pcfg(c, cfg) != `WMSC_PC_OFF));
  endfunction : ch_on

  // mux selection: bit 3 marks a differential pair
  function automatic logic [3:0] ch_sel(input logic [2:0] c, input logic [11:0] cfg);
    ch_sel = {pcfg(c, cfg) == `WMSC_PC_DIFF, c};
  endfunction : ch_sel

  // next enabled channel after cur, wrapping; cur itself when none other
  function automatic logic [2:0] nxt_ch(input logic [2:0] cur, input logic [11:0] cfg,
                                       input logic e8);
    logic [2:0] c;
    nxt_ch = cur;
    for (int i = 8; i >= 1; i--) begin
      c = cur + 3'(i);
      if (ch_on(c, cfg, e8)) begin
        nxt_ch = c;
      end
    end
  endfunction : nxt_ch

  // address decode for the smaller variant drops the two upper bits
  function automatic logic [3:0] amask(input logic [3:0] a, input logic e8);
    amask = e8 ? a : {2'b00, a[1:0]};  // [R19]
  endfunction : amask

  // limit store, the only memory of the block
  wmsc_ram u_ram (
    .pclk  (pclk),
    .we    (st_ff.we),
    .waddr (st_ff.wa),
    .wdata (st_ff.wd),
    .raddr (st_ff.ra),
    .rdata (ram_q)
  );

  // next-state logic
  always_comb begin
    logic       ck_r;    // serial clock rising
    logic       cs_f;    // select falling
    logic       cs_r;    // select rising
    logic       csn;     // synced select
    logic       os_r;    // timebase rising
    logic       tick;    // half-rate sequencing enable
    logic       fail;    // compare result
    logic [7:0] nc;      // bit count including the new bit
    logic [15:0] shn;    // shift register including the new bit
    logic [4:0] nlim;    // number of limits
    logic [3:0] nw;      // next limit index
    logic [7:0] c;       // trial code
    nxt_st = st_ff;
    // two flops per pin before use, third flop only for edges
    nxt_st.ck_s = {st_ff.ck_s[1:0], serial_clk};      // [R28]
    nxt_st.cs_s = {st_ff.cs_s[1:0], cs_n};            // [R28]
    nxt_st.os_s = {st_ff.os_s[1:0], conversion_timebase};
    nxt_st.di_s = {st_ff.di_s[0], serial_in_line};
    nxt_st.cp_s = {st_ff.cp_s[0], cmp_above};
    ck_r = st_ff.ck_s[1] & ~st_ff.ck_s[2];            // [R15]
    csn  = st_ff.cs_s[1];
    cs_f = ~st_ff.cs_s[1] & st_ff.cs_s[2];
    cs_r = st_ff.cs_s[1] & ~st_ff.cs_s[2];
    os_r = st_ff.os_s[1] & ~st_ff.os_s[2];
    tick = os_r & st_ff.div;                          // [R14]
    if (os_r) begin
      nxt_st.div = ~st_ff.div;
    end
    nlim = st_ff.eight ? 5'h10 : 5'h04;
    nc   = st_ff.bcnt + 8'h01;
    shn  = {st_ff.sh[14:0], st_ff.di_s[1]};
    nxt_st.we    = 1'b0;
    nxt_st.cdone = 1'b0;
    nxt_st.ld    = {st_ff.ld[0], 1'b0};
    nxt_st.sdoe  = ~csn;
    fail = 1'b0;
    nw   = 4'h0;
    c    = st_ff.code;
    // select-high time, saturating at the longer limit
    if (csn && os_r && st_ff.cshi != `WMSC_CSHI_8CH) begin
      nxt_st.cshi = st_ff.cshi + 6'h01;
    end
    // successive approximation, one bit per tick; start on a tick so the first trial settles
    if (!st_ff.busy && st_ff.creq && tick) begin
      nxt_st.busy = 1'b1;
      nxt_st.creq = 1'b0;
      nxt_st.mux  = st_ff.csel;
      nxt_st.code = 8'h80;
      nxt_st.bitp = 3'h7;
    end else if (st_ff.busy && tick) begin
      if (!st_ff.cp_s[1]) begin
        c[st_ff.bitp] = 1'b0;           // input below trial level
      end
      if (st_ff.bitp == 3'h0) begin
        nxt_st.busy  = 1'b0;            // eight ticks, sixteen periods   [R14]
        nxt_st.cdone = 1'b1;
        nxt_st.res   = c;               // [R22]
      end else begin
        c[st_ff.bitp - 3'h1] = 1'b1;
        nxt_st.bitp = st_ff.bitp - 3'h1;
      end
      nxt_st.code = c;
    end
    // watchdog scan: one conversion and one compare per enabled limit, disabled limits skipped
    if (st_ff.mode == `WMSC_M_WD && !st_ff.test) begin
      nw = st_ff.eight ? st_ff.widx + 4'h1 : {2'b00, st_ff.widx[1:0] + 2'b01};
      unique case (st_ff.ws)
        WS_PICK: begin
          if (!st_ff.intf) begin
            nxt_st.ra = st_ff.widx;
            if (ch_on(st_ff.widx[3:1], st_ff.cfg, st_ff.eight)) begin
              nxt_st.creq = 1'b1;      // differential value, lower channel limits [R4]
              nxt_st.csel = ch_sel(st_ff.widx[3:1], st_ff.cfg);
              nxt_st.ws   = WS_CONV;
            end else begin
              nxt_st.widx = nw;
              if (st_ff.found && nw == st_ff.tag) begin
                nxt_st.intf = 1'b1;
              end
            end
          end
        end
        WS_CONV: begin
          if (st_ff.cdone && !st_ff.creq) begin  // a waiting request marks a stale result
            // limit byte and result share the same binary weighting   [R7]
            fail = st_ff.widx[0] ? (st_ff.res > ram_q) : (st_ff.res < ram_q); // [R18]
            if (fail) begin
              nxt_st.stat[st_ff.widx] = 1'b1;           // [R20]
            end
            if (fail && !st_ff.found) begin
              nxt_st.found = 1'b1;                      // [R20]
              nxt_st.tag   = st_ff.widx;
            end
            // interrupt once the remaining limits were checked again [R3] [R17]
            if ((st_ff.found || fail) && nw == (st_ff.found ? st_ff.tag : st_ff.widx)) begin
              nxt_st.intf = 1'b1;
            end
            nxt_st.widx = nw;
            nxt_st.ws   = WS_PICK;
          end
        end
      endcase
    end
    // conversion results go lsb first into the output register
    if (st_ff.cdone && (st_ff.mode == `WMSC_M_CONV1 || st_ff.mode == `WMSC_M_AUTO)) begin
      nxt_st.osh  = {rev8(st_ff.res), 16'h0000};        // [R16]
      nxt_st.ocnt = 4'h8;
    end
    // serial shifting on synced serial clock rise
    if (ck_r && !csn) begin
      nxt_st.sdo = st_ff.osh[23];                       // stable until next rise [R15]
      nxt_st.osh = {st_ff.osh[22:0], 1'b0};
      if (st_ff.ocnt != 4'h0) begin
        nxt_st.ocnt = st_ff.ocnt - 4'h1;
        if (st_ff.ocnt == 4'h1 && st_ff.mode == `WMSC_M_AUTO) begin
          nxt_st.ach  = nxt_ch(st_ff.ach, st_ff.cfg, st_ff.eight); // [R12]
          nxt_st.creq = 1'b1;
          nxt_st.csel = ch_sel(nxt_ch(st_ff.ach, st_ff.cfg, st_ff.eight), st_ff.cfg);
        end
      end
      if (!st_ff.rdout && !st_ff.test) begin            // [R13]
        nxt_st.sh = shn;
        if (st_ff.bcnt != `WMSC_BCNT_MAX) begin
          nxt_st.bcnt = nc;
        end
        if (nc == `WMSC_N_MODE) begin
          nxt_st.cmd  = shn[3:0];                       // [R1] [R26]
          nxt_st.bidx = 5'h00;
          if (shn[3:0] == `WMSC_M_TEST) begin
            nxt_st.test = 1'b1;                         // [R13]
            nxt_st.mode = shn[3:0];                     // [R13]
          end
          if (shn[3:0] == `WMSC_M_RDALL) begin
            nxt_st.ra   = 4'h0;                         // lower limit of channel zero [R10]
            nxt_st.ld   = 2'b01;
            nxt_st.bidx = 5'h01;
          end
        end
        if (nc > `WMSC_N_MODE) begin
          unique case (st_ff.cmd)
            `WMSC_M_WD, `WMSC_M_AUTO: begin
              if (nc == `WMSC_N_LONG) begin
                nxt_st.cfg  = shn[11:0];                // [R2] [R24]
                nxt_st.ach  = nxt_ch(3'h7, shn[11:0], st_ff.eight);
                nxt_st.creq = (st_ff.cmd == `WMSC_M_AUTO); // [R12]
                nxt_st.csel = ch_sel(nxt_ch(3'h7, shn[11:0], st_ff.eight), shn[11:0]);
              end
            end
            `WMSC_M_WRONE: begin
              if (nc == `WMSC_N_LONG) begin
                nxt_st.we = 1'b1;                       // [R6] [R18]
                nxt_st.wa = amask(shn[11:8], st_ff.eight);
                nxt_st.wd = rev8(shn[7:0]);             // [R16]
              end
            end
            `WMSC_M_WRALL: begin
              if (nc >= `WMSC_N_BYTE1 && nc[2:0] == 3'h4 && st_ff.bidx < nlim) begin
                nxt_st.we   = 1'b1;                     // [R8]
                nxt_st.wa   = st_ff.bidx[3:0];
                nxt_st.wd   = rev8(shn[7:0]);
                nxt_st.bidx = st_ff.bidx + 5'h01;
              end
            end
            `WMSC_M_RDONE: begin
              if (nc == `WMSC_N_SHORT) begin
                nxt_st.ra = amask(shn[3:0], st_ff.eight); // [R9]
                nxt_st.ld = 2'b01;
              end
            end
            `WMSC_M_RDALL: begin
              if (nc[2:0] == 3'h4 && st_ff.bidx < nlim) begin
                nxt_st.ra   = st_ff.bidx[3:0];          // [R10]
                nxt_st.ld   = 2'b01;
                nxt_st.bidx = st_ff.bidx + 5'h01;
              end
            end
            `WMSC_M_CONV1: begin
              if (nc == `WMSC_N_SHORT) begin
                nxt_st.creq = 1'b1;                     // [R11]
                nxt_st.csel = shn[3:0];
              end
            end
            default: begin
            end
          endcase
        end
        // a completed command switches mode and clears the flags    [R23]
        if ((nc == `WMSC_N_LONG && (st_ff.cmd == `WMSC_M_WD || st_ff.cmd == `WMSC_M_AUTO ||
             st_ff.cmd == `WMSC_M_WRONE)) ||
            (nc == `WMSC_N_SHORT && (st_ff.cmd == `WMSC_M_RDONE ||
             st_ff.cmd == `WMSC_M_CONV1)) ||
            (nc == `WMSC_N_BYTE1 && st_ff.cmd == `WMSC_M_WRALL) ||
            (nc == `WMSC_N_MODE && shn[3:0] == `WMSC_M_RDALL)) begin
          nxt_st.mode  = (nc == `WMSC_N_MODE) ? shn[3:0] : st_ff.cmd;
          nxt_st.pf    = 1'b0;
          nxt_st.intf  = 1'b0;
          nxt_st.found = 1'b0;
          nxt_st.stat  = 16'h0000;
          nxt_st.widx  = 4'h0;
          nxt_st.ws    = WS_PICK;
        end
      end
    end
    // limit data arrives two cycles after its read address
    if (st_ff.ld[1]) begin
      nxt_st.osh = {rev8(ram_q), 16'h0000};             // [R16]
    end
    // select low after a long high in monitoring gives the readout
    if (cs_f && !st_ff.test) begin
      nxt_st.cshi = 6'h00;
      if (st_ff.mode == `WMSC_M_WD &&
          st_ff.cshi >= (st_ff.eight ? `WMSC_CSHI_8CH : `WMSC_CSHI_2CH)) begin // [R25]
        nxt_st.rdout = 1'b1;                            // [R5]
        nxt_st.osh   = st_ff.eight ? {st_ff.stat, st_ff.tag, st_ff.pf, 3'h0}
                                   : {st_ff.stat[3:0], st_ff.tag, st_ff.pf, 15'h0000};
      end
    end
    // select release abandons any partial command                   [R27]
    if (cs_r) begin
      nxt_st.bcnt  = 8'h00;
      nxt_st.rdout = 1'b0;
      if (st_ff.rdout) begin
        nxt_st.intf  = 1'b0;                            // readout rearms the scan
        nxt_st.found = 1'b0;
        nxt_st.stat  = 16'h0000;
        nxt_st.widx  = 4'h0;
        nxt_st.ws    = WS_PICK;
      end
    end
    // crossing direction pins exist only for the two-channel variant
    nxt_st.belw_n = st_ff.eight | ~(st_ff.intf & (st_ff.stat[0] | st_ff.stat[2]));
    nxt_st.abov_n = st_ff.eight | ~(st_ff.intf & (st_ff.stat[1] | st_ff.stat[3]));
    // apb slave: ready in the first access cycle
    nxt_st.pready  = 1'b0;
    nxt_st.pslverr = 1'b0;
    if (psel && !penable && !st_ff.pready) begin
      nxt_st.pready = 1'b1;
      unique case (paddr)
        `WMSC_A_CFG:   nxt_st.prdata = {31'h0, st_ff.eight};
        `WMSC_A_STAT:  nxt_st.prdata = {24'h0, st_ff.intf, st_ff.busy, st_ff.test,
                                        st_ff.pf, st_ff.mode};
        `WMSC_A_CROSS: nxt_st.prdata = {12'h0, st_ff.tag, st_ff.stat};
        `WMSC_A_RES:   nxt_st.prdata = {24'h0, st_ff.res};
        default: begin
          nxt_st.prdata  = 32'h0;               // unmapped: error, zero data
          nxt_st.pslverr = 1'b1;
        end
      endcase
    end
    if (psel && penable && st_ff.pready && pwrite && paddr == `WMSC_A_CFG) begin
      nxt_st.eight = pwdata[0];                 // variant steers decode and scan
    end
  end

  // single state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state register
  assign prdata         = st_ff.prdata;
  assign pready         = st_ff.pready;
  assign pslverr        = st_ff.pslverr;
  assign serial_out_o   = st_ff.sdo;
  assign serial_out_oe  = st_ff.sdoe;
  assign int_out        = st_ff.cp_s[1] & 1'b0;
  assign int_oe         = st_ff.intf;
  assign eoc            = ~st_ff.busy;
  assign below_window_n = st_ff.belw_n;
  assign above_window_n = st_ff.abov_n;
  assign mux_sel        = st_ff.mux;
  assign dac_code       = st_ff.code;
endmodule : wmsc_top

// ===== verilog/wmsc_map.svh
// wmsc_map.svh: offsets, codes, reset values and counts of the window monitor
// assumes: included by the package and the top module by bare name
`ifndef WMSC_MAP_SVH
`define WMSC_MAP_SVH
// mode codes, first four bits of a command word
`define WMSC_M_WD      4'h8
`define WMSC_M_WRONE   4'h9
`define WMSC_M_WRALL   4'hA
`define WMSC_M_RDONE   4'hB
`define WMSC_M_CONV1   4'hC
`define WMSC_M_TEST    4'hD
`define WMSC_M_AUTO    4'hE
`define WMSC_M_RDALL   4'hF
// bit counts at which command fields complete
`define WMSC_N_MODE    8'h04
`define WMSC_N_SHORT   8'h08
`define WMSC_N_LONG    8'h10
`define WMSC_N_BYTE1   8'h0C
// select-high limits in oscillator periods, and the saturation value
`define WMSC_CSHI_2CH  6'h08
`define WMSC_CSHI_8CH  6'h20
// apb byte offsets
`define WMSC_A_CFG     12'h000
`define WMSC_A_STAT    12'h004
`define WMSC_A_CROSS   12'h008
`define WMSC_A_RES     12'h00C
// reset value and bit counter saturation
`define WMSC_CFG_RST   1'b1
`define WMSC_BCNT_MAX  8'hFF
// pair configuration codes
`define WMSC_PC_SE     3'h0
`define WMSC_PC_DIFF   3'h1
`define WMSC_PC_OFF    3'h3
`endif

// ===== verilog/wmsc_pkg.sv
// wmsc_pkg: types of the window monitor serial command port
// assumes: wmsc_map.svh on the include path
`include "wmsc_map.svh"
package wmsc_pkg;
  // watchdog scan states
  typedef enum logic [1:0] {WS_PICK, WS_CONV} wmsc_ws_t;
  // whole state of the top module
  typedef struct packed {
    logic [2:0]  ck_s;    // serial clock sync + previous
    logic [2:0]  cs_s;    // select sync + previous
    logic [2:0]  os_s;    // timebase sync + previous
    logic [1:0]  di_s;    // serial input sync
    logic [1:0]  cp_s;    // comparator sync
    logic        div;     // timebase divide by two
    logic [5:0]  cshi;    // select-high time in timebase periods
    logic [7:0]  bcnt;    // command bit counter
    logic [15:0] sh;      // input shift register
    logic [3:0]  cmd;     // latched mode code
    logic [3:0]  mode;    // active mode
    logic        rdout;   // transaction is a crossing readout
    logic        pf;      // power-fail flag
    logic        test;    // sticky test mode
    logic [11:0] cfg;     // pair configuration
    logic [23:0] osh;     // output shift register
    logic        sdo;     // serial output bit
    logic        sdoe;    // serial output enable
    logic [4:0]  bidx;    // byte index for all-limit modes
    logic        we;      // limit store write strobe
    logic [3:0]  wa;      // limit store write address
    logic [7:0]  wd;      // limit store write data
    logic [3:0]  ra;      // limit store read address
    logic [1:0]  ld;      // pending load of read data
    logic        creq;    // conversion request
    logic [3:0]  csel;    // requested mux selection
    logic        busy;    // conversion running
    logic        cdone;   // conversion finished pulse
    logic [3:0]  mux;     // mux selection driven out
    logic [7:0]  code;    // successive approximation code
    logic [2:0]  bitp;    // bit under trial
    logic [7:0]  res;     // last result
    logic [3:0]  ocnt;    // result bits still to send in single and auto modes
    logic [2:0]  ach;     // auto scan channel
    wmsc_ws_t    ws;      // watchdog scan state
    logic [3:0]  widx;    // limit under check
    logic [3:0]  tag;     // first crossing limit
    logic [15:0] stat;    // crossing status per limit
    logic        found;   // first crossing seen
    logic        intf;    // interrupt pending
    logic        eight;   // eight-channel variant
    logic        pready;  // apb ready
    logic        pslverr; // apb error
    logic [31:0] prdata;  // apb read data
    logic        belw_n;  // lower limit crossed, low active
    logic        abov_n;  // upper limit crossed, low active
  } wmsc_st_t;
endpackage : wmsc_pkg

// ===== verilog/wmsc_ram.sv
// wmsc_ram: sixteen by eight limit store, registered read data
// assumes: one clock, write and read address from registered logic
`timescale 1ns/100ps
module wmsc_ram (
  input  wire logic       pclk,
  input  wire logic       we,
  input  wire logic [3:0] waddr,
  input  wire logic [7:0] wdata,
  input  wire logic [3:0] raddr,
  output logic      [7:0] rdata
);
  logic [7:0] mem [16];  // limit words, even lower, odd upper

  // no reset: limit contents are undefined until software writes them
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : wmsc_ram

// ===== sim/wmsc_props.sv
// wmsc_props: port assertions for the window monitor serial command port
// assumes: bound to wmsc_top; all checks in the pclk domain
`timescale 1ns/100ps
module wmsc_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        cs_n,
  input wire logic        serial_out_oe,
  input wire logic        int_out,
  input wire logic        eoc
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // zero-wait slave: ready in the access cycle, for one cycle only
  apb_ready_a: assert property (psel && !penable |=> pready) else $error("ready late");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
  // unmapped offsets are refused with zero data
  unmapped_err_a: assert property (psel && !penable && paddr > 12'h00C |=> pslverr)
    else $error("no error on unmapped");
  err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  err_data_a: assert property (pslverr |-> prdata == 32'h0) else $error("data on error");
  // output released once select has been high long enough to pass the synchroniser
  oe_release_a: assert property (cs_n [*5] |-> !serial_out_oe) else $error("output held");
  // open-drain interrupt never drives high
  int_drain_a: assert property (!int_out) else $error("interrupt driven high");
  // conversion bounded by eighteen timebase periods plus sync
  conv_time_a: assert property ($fell(eoc) |-> ##[1:200] eoc) else $error("conversion long");
  cover property ($fell(eoc));
  cover property (pslverr);
  cover property ($rose(serial_out_oe));
endmodule : wmsc_props
bind wmsc_top wmsc_props wmsc_props_i (.*);

// ===== sim/wmsc_host.sv
// wmsc_host: host serial master model with an 800 ns serial clock
// assumes: pclk at 100 ns; serial clock runs only inside frames
`timescale 1ns/100ps
module wmsc_host (
  input  wire logic pclk,
  output logic      cs_n,
  output logic      serial_clk,
  output logic      serial_in_line,
  input  wire logic serial_out_o,
  input  wire logic serial_out_oe
);
  logic        last = 0; // last bit driven by the device
  logic [31:0] r    = 0; // bits seen, newest at bit 0
  // released line shows the inverse, never a lucky stale value
  wire line = serial_out_oe ? serial_out_o : !last;
  initial begin
    cs_n = 1;
    serial_clk = 0;
    serial_in_line = 0;
  end
  always @(posedge pclk) if (serial_out_oe) last <= serial_out_o;
  // select low opens a frame
  task sel;
    @(posedge pclk);
    cs_n <= 0;
    repeat (6) @(posedge pclk);
  endtask : sel
  // short select high: leaves monitoring for a new command
  task desel;
    cs_n <= 1;
    repeat (8) @(posedge pclk);
  endtask : desel
  // caller supplies the leading one; output sampled well after the fall
  task bits(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      serial_in_line <= v[i];
      serial_clk <= 0;
      repeat (3) @(posedge pclk);
      r = {r[30:0], line};
      @(posedge pclk);
      serial_clk <= 1;
      repeat (4) @(posedge pclk);
    end
    serial_clk <= 0;
    repeat (3) @(posedge pclk);
    r = {r[30:0], line};
  endtask : bits
endmodule : wmsc_host

// ===== sim/testbench.sv
// testbench: apb and serial command checks of wmsc_top
// assumes: design files and wmsc_map.svh compiled before this file
`timescale 1ns/100ps
`include "wmsc_map.svh"
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic cs_n, serial_clk, serial_in_line, serial_out_o, serial_out_oe, int_out, int_oe;
  logic conversion_timebase = 0, cmp_above = 0, eoc, below_window_n, above_window_n, e, seen;
  logic [3:0] mux_sel, m, md;
  logic [7:0] dac_code;
  int bad_count = 0, n_checks = 0, n;
  wmsc_top wmsc_top_i (.*);
  wmsc_host wmsc_host_i (.*);
  always #50 pclk = ~pclk;
  always #500 conversion_timebase = ~conversion_timebase;
  // analog input sits just above 5A on every channel
  always @(posedge pclk) cmp_above <= (dac_code <= 8'h5A);
  function automatic logic [7:0] rev8(input logic [7:0] b);
    rev8 = {<<{b}};
  endfunction : rev8
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task wr1(input logic [3:0] a, input logic [7:0] d);
    wmsc_host_i.sel();
    wmsc_host_i.bits({`WMSC_M_WRONE, a, rev8(d)}, 16);
    wmsc_host_i.desel();
  endtask : wr1
  task rd1(input logic [3:0] a, input logic [7:0] d);
    wmsc_host_i.sel();
    wmsc_host_i.bits({`WMSC_M_RDONE, a}, 8);
    wmsc_host_i.bits(0, 8);
    chk(rev8(wmsc_host_i.r[7:0]), d);
    wmsc_host_i.desel();
  endtask : rd1
  task results;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  initial begin
    repeat (30000) @(posedge pclk);
    bad_count++;
    results();
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h000, 0);
    chk(q, 1);
    apb(0, 12'h004, 0);
    chk(q[4:0], 5'h18);
    apb(1, 12'h010, 0);
    chk(e, 1);
    // power-up select low gives the crossing readout
    wmsc_host_i.sel();
    wmsc_host_i.bits(0, 21);
    chk(wmsc_host_i.r[20:0], 21'h000001);
    wmsc_host_i.desel();
    wr1(4'h3, 8'hA5);
    apb(0, 12'h004, 0);
    chk(q[4], 0);
    // abandoned write must leave the limit alone
    wmsc_host_i.sel();
    wmsc_host_i.bits({`WMSC_M_WRONE, 8'h30}, 12);
    wmsc_host_i.desel();
    rd1(4'h3, 8'hA5);
    apb(1, 12'h000, 0);
    wr1(4'hD, 8'h3C);
    rd1(4'h1, 8'h3C);
    apb(1, 12'h000, 1);
    wmsc_host_i.sel();
    wmsc_host_i.bits(`WMSC_M_WRALL, 4);
    for (int k = 0; k < 16; k++) wmsc_host_i.bits(rev8({k[3:0], ~k[3:0]}), 8);
    wmsc_host_i.desel();
    wmsc_host_i.sel();
    wmsc_host_i.bits(`WMSC_M_RDALL, 4);
    for (int k = 0; k < 16; k++) begin
      wmsc_host_i.bits(0, 8);
      chk(rev8(wmsc_host_i.r[7:0]), {k[3:0], ~k[3:0]});
    end
    wmsc_host_i.desel();
    wmsc_host_i.sel();
    wmsc_host_i.bits({`WMSC_M_CONV1, 4'h3}, 8);
    seen = 0;
    n = 0;
    while (!(seen && eoc === 1) && n < 400) begin
      @(posedge pclk);
      n++;
      if (eoc === 0) {seen, m} = {1'b1, mux_sel};
    end
    chk(n < 400, 1);
    chk(m, 4'h3);
    wmsc_host_i.bits(0, 8);
    chk(rev8(wmsc_host_i.r[7:0]), 8'h5A);
    wmsc_host_i.desel();
    for (int j = 0; j < 2; j++) begin
      md = j ? `WMSC_M_WD : `WMSC_M_AUTO;
      wmsc_host_i.sel();
      wmsc_host_i.bits({md, 12'h000}, 16);
      wmsc_host_i.desel();
      apb(0, 12'h004, 0);
      chk(q[3:0], md);
    end
    n = 0;
    while (int_oe !== 1 && n < 8000) begin
      @(posedge pclk);
      n++;
    end
    chk(int_oe, 1);
    chk({below_window_n, above_window_n, int_out}, 3'b110);
    apb(0, 12'h008, 0);
    chk(q, 32'h0001554A);
    wmsc_host_i.sel();
    wmsc_host_i.bits(0, 21);
    chk(wmsc_host_i.r[20:0], 21'hAA942);
    wmsc_host_i.desel();
    wmsc_host_i.sel();
    wmsc_host_i.bits(`WMSC_M_TEST, 4);
    wmsc_host_i.desel();
    wr1(4'h3, 8'h00);
    apb(0, 12'h004, 0);
    chk(q[5:0], {2'b10, `WMSC_M_TEST});
    results();
  end
endmodule : testbench
